/* sec_defines.vh */
`ifndef SEC_DEFINES_VH
`define SEC_DEFINES_VH

// ---------------------------------------------------------------
// opcodes and sub-commands
// ---------------------------------------------------------------
`define SEC_OP_MISC          2'h0
`define SEC_OP_WRITE         2'h1
`define SEC_OP_READ          2'h2
`define SEC_OP_ERASE         2'h3
`define SEC_SUB_LOCK         2'h0
`define SEC_SUB_FILL         2'h1
`define SEC_SUB_CLEAR        2'h2
`define SEC_SUB_UNLOCK       2'h3

// ---------------------------------------------------------------
// frame field lengths (bits after the start bit)
// ---------------------------------------------------------------
`define SEC_HDR_BITS_X16     5'h0c
`define SEC_HDR_BITS_X8      5'h0d
`define SEC_DATA_BITS_X16    5'h10
`define SEC_DATA_BITS_X8     5'h08

// ---------------------------------------------------------------
// array and reset values
// ---------------------------------------------------------------
`define SEC_WORDS            512
`define SEC_ERASED_WORD      16'hffff
`define SEC_ERASED_BYTE      8'hff

// ---------------------------------------------------------------
// timing and read-ahead fifo size
// ---------------------------------------------------------------
`define SEC_CLK_MHZ          10
`define SEC_PROGRAM_CYCLE_TIME_US 5000
`define SEC_PROGRAM_CYCLES   (`SEC_PROGRAM_CYCLE_TIME_US * `SEC_CLK_MHZ)
`define SEC_FIFO_WIDTH       16
`define SEC_FIFO_DEPTH       8
`define SEC_FIFO_AW          3

`endif

/* sec_fifo.v */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// read-ahead fifo
// ---------------------------------------------------------------
module sec_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	input  wire             flush,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] store_q [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;

	// one extra pointer bit tells full from empty
	assign out_valid = (wr_q != rd_q);
	assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_data  = store_q[rd_q[AW-1:0]];

	// pointers; flush drops everything at once
	always @(posedge clk) begin
		if (rst || flush) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && in_ready) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	// storage, written only on an accepted push
	always @(posedge clk) begin
		if (in_valid && in_ready && !flush) begin
			store_q[wr_q[AW-1:0]] <= in_data;
		end
	end
endmodule // sec_fifo

/* sec_port.v */
`timescale 1ns/1ns
`include "sec_defines.vh"
module sec_port #(
	parameter PROG_CYCLES = `SEC_PROGRAM_CYCLES
) (
	// system
	input  wire clk,
	input  wire rst,
	// serial pins from the host
	input  wire chip_select,
	input  wire serial_clock_in,
	input  wire serial_in,
	input  wire org_sel,
	// serial output pin
	output reg  serial_out_q,
	output reg  serial_out_oe_n_q,
	// status
	output reg  busy_q
);
	// ---------------------------------------------------------------
	// local codes
	// ---------------------------------------------------------------
	localparam ST_IDLE  = 3'h0;
	localparam ST_HDR   = 3'h1;
	localparam ST_DATA  = 3'h2;
	localparam ST_ARMED = 3'h3;
	localparam ST_READ  = 3'h4;
	localparam ST_DONE  = 3'h5;
	localparam PK_ERASE = 2'h0;
	localparam PK_WRITE = 2'h1;
	localparam PK_CLEAR = 2'h2;
	localparam PK_FILL  = 2'h3;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	reg        cs_s1, cs_s2, cs_s3;
	reg        sk_s1, sk_s2, sk_s3;
	reg        di_s1, di_s2;
	reg        org_s1, org_s2;

	// two flops per pin; the third cs/sk flop only feeds edge detection
	always @(posedge clk) begin
		if (rst) begin
			cs_s1  <= 1'b0;
			cs_s2  <= 1'b0;
			cs_s3  <= 1'b0;
			sk_s1  <= 1'b0;
			sk_s2  <= 1'b0;
			sk_s3  <= 1'b0;
			di_s1  <= 1'b0;
			di_s2  <= 1'b0;
			org_s1 <= 1'b1;
			org_s2 <= 1'b1;
		end else begin
			cs_s1  <= chip_select;
			cs_s2  <= cs_s1;
			cs_s3  <= cs_s2;
			sk_s1  <= serial_clock_in;
			sk_s2  <= sk_s1;
			sk_s3  <= sk_s2;
			di_s1  <= serial_in;
			di_s2  <= di_s1;
			org_s1 <= org_sel;
			org_s2 <= org_s1;
		end
	end

	wire sk_rise = sk_s2 & ~sk_s3;
	wire sk_fall = ~sk_s2 & sk_s3;
	wire cs_fall = ~cs_s2 & cs_s3;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	reg [2:0]  state_q;
	reg [4:0]  cnt_q;
	reg [12:0] hdr_q;
	reg [15:0] data_q;
	reg        unlock_q;
	reg        status_q;
	reg        rel_pend_q;
	reg [31:0] prog_cnt_q;
	reg [1:0]  prog_kind_q;
	reg [9:0]  prog_addr_q;
	reg        prog_org_q;
	reg [9:0]  pf_addr_q;
	reg        pf_active_q;
	reg [15:0] rd_sh_q;
	reg [4:0]  bits_left_q;
	reg        rd_bit_q;
	reg [15:0] mem_q [0:`SEC_WORDS-1];
	integer    k;

	// ---------------------------------------------------------------
	// header decode
	// ---------------------------------------------------------------
	wire        word_mode = org_s2;
	wire [4:0]  hdr_len   = word_mode ? `SEC_HDR_BITS_X16 : `SEC_HDR_BITS_X8;
	wire [4:0]  data_len  = word_mode ? `SEC_DATA_BITS_X16 : `SEC_DATA_BITS_X8;
	wire [12:0] hdr_nx    = {hdr_q[11:0], di_s2};
	wire [1:0]  op        = word_mode ? hdr_nx[11:10] : hdr_nx[12:11];
	wire [1:0]  sub       = word_mode ? hdr_nx[9:8] : hdr_nx[10:9];
	// the top address bit is shifted in and then dropped
	wire [9:0]  addr      = word_mode ? {1'b0, hdr_nx[8:0]} : hdr_nx[9:0];
	wire        hdr_last  = (cnt_q == hdr_len - 5'h01);
	wire        data_last = (cnt_q == data_len - 5'h01);

	// ---------------------------------------------------------------
	// read-ahead path
	// ---------------------------------------------------------------
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [15:0] fifo_out_data;
	wire [15:0] pf_word  = mem_q[word_mode ? pf_addr_q[8:0] : pf_addr_q[9:1]];
	wire [7:0]  pf_byte  = pf_addr_q[0] ? pf_word[7:0] : pf_word[15:8];
	// bytes ride msb-aligned so the shifter is the same in both modes
	wire [15:0] pf_data  = word_mode ? pf_word : {pf_byte, 8'h00};
	wire        fifo_pop = (state_q == ST_READ) && sk_rise && (bits_left_q == 5'h00);

	sec_fifo #(
		.WIDTH (`SEC_FIFO_WIDTH),
		.DEPTH (`SEC_FIFO_DEPTH),
		.AW    (`SEC_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.flush     (~cs_s2),
		.in_valid  (pf_active_q),
		.in_ready  (fifo_in_ready),
		.in_data   (pf_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// ---------------------------------------------------------------
	// frame decoder, program timer, read serializer
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			state_q     <= ST_IDLE;
			cnt_q       <= 5'h00;
			hdr_q       <= 13'h0000;
			data_q      <= 16'h0000;
			unlock_q    <= 1'b0;
			status_q    <= 1'b0;
			rel_pend_q  <= 1'b0;
			busy_q      <= 1'b0;
			prog_cnt_q  <= 32'h0000_0000;
			prog_kind_q <= PK_ERASE;
			prog_addr_q <= 10'h000;
			prog_org_q  <= 1'b1;
			pf_addr_q   <= 10'h000;
			pf_active_q <= 1'b0;
			rd_sh_q     <= 16'h0000;
			bits_left_q <= 5'h00;
			rd_bit_q    <= 1'b0;
		end else begin
			// self-timed cycle runs on the system clock, no serial clock needed
			if (busy_q) begin
				prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
				if (prog_cnt_q == 32'h0000_0001) begin
					busy_q <= 1'b0;
				end
			end
			// release status drive on the fall after a dummy one
			if (status_q && cs_s2 && sk_rise && di_s2) begin
				rel_pend_q <= 1'b1;
			end else if (rel_pend_q && sk_fall) begin
				rel_pend_q <= 1'b0;
				status_q   <= 1'b0;
			end
			// prefetch stalls on a full fifo and wraps at the array end
			if (pf_active_q && fifo_in_ready && cs_s2) begin
				pf_addr_q <= word_mode ? {1'b0, pf_addr_q[8:0] + 9'h001} : pf_addr_q + 10'h001;
			end
			if (!cs_s2) begin
				// deselect clears the decoder; a bit sampled now would be stale
				state_q     <= ST_IDLE;
				cnt_q       <= 5'h00;
				pf_active_q <= 1'b0;
				if (cs_fall && state_q == ST_ARMED && unlock_q && !busy_q) begin
					busy_q     <= 1'b1;
					prog_cnt_q <= PROG_CYCLES;
					status_q   <= 1'b1;
				end
			end else if (sk_rise) begin
				case (state_q)
				ST_IDLE: begin
					// leading zeros are idle clocks; a one opens the frame
					if (di_s2 && !busy_q) begin
						state_q <= ST_HDR;
						cnt_q   <= 5'h00;
					end
				end
				ST_HDR: begin
					hdr_q <= hdr_nx;
					cnt_q <= cnt_q + 5'h01;
					if (hdr_last) begin
						cnt_q       <= 5'h00;
						prog_addr_q <= addr;
						prog_org_q  <= word_mode;
						case (op)
						`SEC_OP_READ: begin
							state_q     <= ST_READ;
							pf_addr_q   <= addr;
							pf_active_q <= 1'b1;
							bits_left_q <= 5'h00;
							rd_bit_q    <= 1'b0;
						end
						`SEC_OP_ERASE: begin
							prog_kind_q <= PK_ERASE;
							state_q     <= ST_ARMED;
						end
						`SEC_OP_WRITE: begin
							prog_kind_q <= PK_WRITE;
							state_q     <= ST_DATA;
						end
						default: begin
							case (sub)
							`SEC_SUB_UNLOCK: begin
								unlock_q <= 1'b1;
								state_q  <= ST_DONE;
							end
							`SEC_SUB_LOCK: begin
								unlock_q <= 1'b0;
								state_q  <= ST_DONE;
							end
							`SEC_SUB_CLEAR: begin
								prog_kind_q <= PK_CLEAR;
								state_q     <= ST_ARMED;
							end
							default: begin
								prog_kind_q <= PK_FILL;
								state_q     <= ST_DATA;
							end
							endcase
						end
						endcase
					end
				end
				ST_DATA: begin
					data_q <= {data_q[14:0], di_s2};
					cnt_q  <= cnt_q + 5'h01;
					if (data_last) begin
						state_q <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					// a further rise before deselect misses the start window
					state_q <= ST_DONE;
				end
				ST_READ: begin
					// word boundaries run back to back, no second leading zero
					if (bits_left_q == 5'h00) begin
						rd_bit_q    <= fifo_out_valid & fifo_out_data[15];
						rd_sh_q     <= {fifo_out_data[14:0], 1'b0};
						bits_left_q <= data_len - 5'h01;
					end else begin
						rd_bit_q    <= rd_sh_q[15];
						rd_sh_q     <= {rd_sh_q[14:0], 1'b0};
						bits_left_q <= bits_left_q - 5'h01;
					end
				end
				default: begin
					state_q <= ST_DONE;
				end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// array update at the end of the program cycle
	// ---------------------------------------------------------------
	wire        commit   = busy_q && (prog_cnt_q == 32'h0000_0001);
	wire [8:0]  prog_w   = prog_org_q ? prog_addr_q[8:0] : prog_addr_q[9:1];
	wire [7:0]  new_byte = (prog_kind_q == PK_WRITE) ? data_q[7:0] : `SEC_ERASED_BYTE;
	wire [15:0] new_word = (prog_kind_q == PK_WRITE) ? data_q : `SEC_ERASED_WORD;
	wire [15:0] fill_w   = prog_org_q ? data_q : {data_q[7:0], data_q[7:0]};

	// a write replaces the whole cell, so it never needs an erase first
	always @(posedge clk) begin
		if (rst) begin
			for (k = 0; k < `SEC_WORDS; k = k + 1) begin
				mem_q[k] <= `SEC_ERASED_WORD;
			end
		end else if (commit) begin
			case (prog_kind_q)
			PK_CLEAR: begin
				for (k = 0; k < `SEC_WORDS; k = k + 1) begin
					mem_q[k] <= `SEC_ERASED_WORD;
				end
			end
			PK_FILL: begin
				for (k = 0; k < `SEC_WORDS; k = k + 1) begin
					mem_q[k] <= fill_w;
				end
			end
			default: begin
				if (prog_org_q) begin
					mem_q[prog_w] <= new_word;
				end else if (prog_addr_q[0]) begin
					mem_q[prog_w] <= {mem_q[prog_w][15:8], new_byte};
				end else begin
					mem_q[prog_w] <= {new_byte, mem_q[prog_w][7:0]};
				end
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// serial output pin
	// ---------------------------------------------------------------
	// released unless streaming read data or reporting status while selected
	always @(posedge clk) begin
		if (rst) begin
			serial_out_q      <= 1'b0;
			serial_out_oe_n_q <= 1'b1;
		end else if (cs_s2 && state_q == ST_READ) begin
			serial_out_q      <= rd_bit_q;
			serial_out_oe_n_q <= 1'b0;
		end else if (cs_s2 && status_q) begin
			serial_out_q      <= ~busy_q;
			serial_out_oe_n_q <= 1'b0;
		end else begin
			serial_out_q      <= 1'b0;
			serial_out_oe_n_q <= 1'b1;
		end
	end
endmodule // sec_port

/* sec_port_properties.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// serial port checker
// ---------------------------------------------------------------
module sec_port_chk #(
	parameter PROG_CYCLES = 50000
) (
	// system
	input wire clk,
	input wire rst,
	// host pins
	input wire chip_select,
	input wire serial_clock_in,
	input wire serial_in,
	input wire org_sel,
	// device pins
	input wire serial_out_q,
	input wire serial_out_oe_n_q,
	input wire busy_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	reg [31:0] busy_cnt_q;
	reg [3:0]  busy_hist_q;
	// busy length, and recent history that masks the ready flip of status
	always @(posedge clk) begin
		if (rst) begin
			busy_cnt_q  <= 32'h0000_0000;
			busy_hist_q <= 4'h0;
		end else begin
			busy_cnt_q  <= busy_q ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
			busy_hist_q <= {busy_hist_q[2:0], busy_q};
		end
	end
	AST_RELEASE_IDLE: assert property (!chip_select [*6] |-> serial_out_oe_n_q)
		else $error("output driven while deselected");
	AST_RESET_QUIET: assert property ($past(rst) |-> serial_out_oe_n_q && !busy_q)
		else $error("output or busy active after reset");
	AST_PROG_LENGTH: assert property ($fell(busy_q) && !$past(rst) |-> busy_cnt_q == PROG_CYCLES)
		else $error("program cycle length wrong");
	AST_PROG_AFTER_DESELECT: assert property ($rose(busy_q) |-> !$past(chip_select, 2))
		else $error("program started while selected");
	AST_HOLD_BUSY: assert property ($rose(busy_q) |-> busy_q [*8])
		else $error("program cycle cut short");
	AST_BUSY_SHOWS_LOW: assert property (busy_q && !serial_out_oe_n_q |-> !serial_out_q)
		else $error("status high while busy");
	AST_READY_SHOWS_HIGH: assert property ($fell(busy_q) && !serial_out_oe_n_q |-> ##[0:2] (serial_out_q || serial_out_oe_n_q))
		else $error("status not high when ready");
	AST_READ_ON_RISE: assert property ((!serial_clock_in [*4]) ##0 (!serial_out_oe_n_q
		&& $past(!serial_out_oe_n_q) && busy_hist_q == 4'h0) |-> $stable(serial_out_q))
		else $error("output moved late in clock low phase");
	cover property ($rose(busy_q));
	cover property ($fell(busy_q) && !serial_out_oe_n_q);
	cover property ($rose(serial_out_oe_n_q) && chip_select);
endmodule // sec_port_chk

bind sec_port sec_port_chk #(.PROG_CYCLES(PROG_CYCLES)) sec_port_chk_inst (
	.clk               (clk),
	.rst               (rst),
	.chip_select       (chip_select),
	.serial_clock_in   (serial_clock_in),
	.serial_in         (serial_in),
	.org_sel           (org_sel),
	.serial_out_q      (serial_out_q),
	.serial_out_oe_n_q (serial_out_oe_n_q),
	.busy_q            (busy_q)
);

/* sec_host.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// host serial master model
// ---------------------------------------------------------------
module sec_host #(
	parameter POWERUP_CYCLES = 10000
) (
	// system
	input  wire clk,
	// serial pins
	output reg  chip_select,
	output reg  serial_clock_in,
	output reg  serial_in,
	input  wire serial_out
);
	// deselected, clock parked low between frames
	initial begin
		chip_select     = 1'h0;
		serial_clock_in = 1'h0;
		serial_in       = 1'h0;
	end
	// no programming until supply has settled for 1 ms
	task powerup;
		repeat (POWERUP_CYCLES) @(negedge clk);
	endtask
	// one bit: data set up a full low phase before the rise; output sampled just before it
	task clk_bit(input b, output s);
		begin
			serial_in = b;
			repeat (4) @(negedge clk);
			s = serial_out;
			serial_clock_in = 1'h1;
			repeat (4) @(negedge clk);
			serial_clock_in = 1'h0;
		end
	endtask
	// select and shift n bits msb first, collecting output samples
	task xfer(input [63:0] v, input integer n, output [63:0] r);
		integer i;
		reg     s;
		begin
			chip_select = 1'h1;
			r = 64'h0000_0000_0000_0000;
			for (i = n - 1; i >= 0; i = i - 1) begin
				clk_bit(v[i], s);
				r = {r[62:0], s};
			end
		end
	endtask
	// select without clocking, to poll status
	task sel;
		begin
			chip_select = 1'h1;
			repeat (6) @(negedge clk);
		end
	endtask
	// deselect right after the last bit; data line no longer meaningful
	task desel;
		begin
			chip_select = 1'h0;
			serial_in = ~serial_in;
			repeat (6) @(negedge clk);
		end
	endtask
endmodule // sec_host

/* sec_port_tb.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// serial port testbench
// ---------------------------------------------------------------
module sec_port_tb;
	localparam PROG = 50;
	reg        clk;
	reg        rst;
	reg        org_sel;
	reg [63:0] r;
	wire       chip_select;
	wire       serial_clock_in;
	wire       serial_in;
	wire       serial_out_q;
	wire       serial_out_oe_n_q;
	wire       busy_q;
	wire       so_pin;
	integer    n_mismatch;
	integer    cmp_count;
	// output pin floats while its enable is off
	assign so_pin = serial_out_oe_n_q ? 1'hz : serial_out_q;
	// 10 MHz clock
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	sec_port #(.PROG_CYCLES(PROG)) sec_port_inst (
		.clk               (clk),
		.rst               (rst),
		.chip_select       (chip_select),
		.serial_clock_in   (serial_clock_in),
		.serial_in         (serial_in),
		.org_sel           (org_sel),
		.serial_out_q      (serial_out_q),
		.serial_out_oe_n_q (serial_out_oe_n_q),
		.busy_q            (busy_q)
	);
	sec_host sec_host_inst (
		.clk             (clk),
		.chip_select     (chip_select),
		.serial_clock_in (serial_clock_in),
		.serial_in       (serial_in),
		.serial_out      (so_pin)
	);
	// ---------------------------------------------------------------
	// compares and shared sequences
	// ---------------------------------------------------------------
	task chk_b(input got, input exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task chk_w(input [63:0] got, input [63:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// read frame plus extra clocks; last samples land in r
	task rd(input [63:0] v, input integer hlen, input integer extra);
		begin
			sec_host_inst.xfer(v << extra, hlen + extra, r);
			sec_host_inst.desel;
			chk_b(so_pin, 1'hz);
		end
	endtask
	// bounded wait for the program cycle to end
	task wait_idle;
		integer k;
		begin
			k = 0;
			while (busy_q === 1'h1 && k < PROG + 20) begin
				@(negedge clk);
				k = k + 1;
			end
			chk_b(k <= PROG, 1'h1);
		end
	endtask
	task prog(input [63:0] v, input integer n);
		begin
			sec_host_inst.xfer(v, n, r);
			sec_host_inst.desel;
			chk_b(busy_q, 1'h1);
			wait_idle;
		end
	endtask
	task refused(input [63:0] v, input integer n);
		begin
			sec_host_inst.xfer(v, n, r);
			sec_host_inst.desel;
			chk_b(busy_q, 1'h0);
		end
	endtask
	// lock and unlock frames change state only, they never start a program cycle
	task ctl(input [63:0] v, input integer n);
		begin
			sec_host_inst.xfer(v, n, r);
			sec_host_inst.desel;
			chk_b(busy_q, 1'h0);
		end
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_reset;
		begin
			chk_b(so_pin, 1'hz);
			// two idle zeros ahead of the start bit must be skipped
			rd({5'h06, 10'h000}, 15, 17);
			chk_w(r[16:0], {1'h0, 16'hffff});
			refused({3'h5, 10'h005, 16'h1234}, 29);
		end
	endtask
	task t_write;
		begin
			ctl({3'h4, 10'h300}, 13);
			sec_host_inst.xfer({3'h5, 10'h205, 16'h1234}, 29, r);
			sec_host_inst.desel;
			sec_host_inst.sel;
			chk_b(so_pin, 1'h0);
			wait_idle;
			repeat (4) @(negedge clk);
			chk_b(so_pin, 1'h1);
			sec_host_inst.clk_bit(1'h1, r[0]);
			repeat (6) @(negedge clk);
			chk_b(so_pin, 1'hz);
			sec_host_inst.desel;
			rd({3'h6, 10'h005}, 13, 17);
			chk_w(r[16:0], {1'h0, 16'h1234});
		end
	endtask
	task t_stream;
		begin
			prog({3'h5, 10'h1ff, 16'ha5c3}, 29);
			prog({3'h5, 10'h000, 16'h5a3c}, 29);
			prog({3'h5, 10'h001, 16'h0f0f}, 29);
			rd({3'h6, 10'h3ff}, 13, 49);
			chk_w(r[48:0], {1'h0, 16'ha5c3, 16'h5a3c, 16'h0f0f});
		end
	endtask
	task t_erase;
		begin
			prog({3'h7, 10'h000}, 13);
			rd({3'h6, 10'h000}, 13, 17);
			chk_w(r[16:0], {1'h0, 16'hffff});
			prog({3'h4, 10'h100, 16'h0ff0}, 29);
			rd({3'h6, 10'h1ff}, 13, 33);
			chk_w(r[32:0], {1'h0, 16'h0ff0, 16'h0ff0});
			prog({3'h4, 10'h200}, 13);
			rd({3'h6, 10'h001}, 13, 17);
			chk_w(r[16:0], {1'h0, 16'hffff});
			ctl({3'h4, 10'h000}, 13);
			refused({3'h5, 10'h001, 16'h0000}, 29);
		end
	endtask
	task t_byte;
		begin
			org_sel = 1'h0;
			ctl({3'h4, 11'h600}, 14);
			prog({3'h5, 11'h407, 8'h9c}, 22);
			rd({3'h6, 11'h006}, 14, 17);
			chk_w(r[16:0], {1'h0, 8'hff, 8'h9c});
			org_sel = 1'h1;
			rd({3'h6, 10'h003}, 13, 17);
			chk_w(r[16:0], {1'h0, 16'hff9c});
		end
	endtask
	// ---------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ---------------------------------------------------------------
	task tally_and_finish;
		begin
			if (n_mismatch == 0 && cmp_count > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask
	// whole run needs about 15000 cycles; over twice that means a hang
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		tally_and_finish;
	end
	initial begin
		rst = 1'h1;
		org_sel = 1'h1;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (8) @(negedge clk);
		rst = 1'h0;
		sec_host_inst.powerup;
		t_reset;
		t_write;
		t_stream;
		t_erase;
		t_byte;
		tally_and_finish;
	end
endmodule // sec_port_tb
